// >>> kpi_keypad.sv
/*
 * Keypad switch model that drives the pins of the pin interrupt block.
 * Assumes the bench says which keys are pressed and at what level.
 */
`timescale 1ns/1ps
`default_nettype none
module kpi_keypad
    import kpi_pkg::*;
(
    // Clock
    input  wire logic                 sys_clk,
    // Key control from the bench
    input  wire logic [KPI_NIMPL-1:0] key_press,
    input  wire logic [KPI_NIMPL-1:0] key_level,
    // Pad pulls from the block
    input  wire logic [KPI_NIMPL-1:0] pull_up_en,
    input  wire logic [KPI_NIMPL-1:0] pull_down_en,
    output logic      [KPI_NIMPL-1:0] pin
);
    // ****************************************************
    // Pin level
    // ****************************************************
    logic [KPI_NIMPL-1:0] last_q = '0;

    // pull sets idle level
    // Floating pins toggle so no stale level hides a fault
    assign pin = (key_press & key_level) | (~key_press & pull_up_en)
               | (~key_press & ~pull_up_en & ~pull_down_en & ~last_q);

    always_ff @(posedge sys_clk)
    begin
        last_q <= pin;
    end
endmodule : kpi_keypad
`default_nettype wire

// >>> kpi_pkg.sv
/*
 * Package for the keypad pin interrupt: register indices, field
 * positions, reset values and shared carrier types.
 * Assumes an 8-bit register port with one-cycle read latency.
 */
package kpi_pkg;

    // ****************************************************
    // Register map
    // ****************************************************
    localparam logic [1:0] KPI_ADDR_STATUS_CONTROL = 2'h0;
    localparam logic [1:0] KPI_ADDR_PIN_ENABLE     = 2'h1;
    localparam logic [1:0] KPI_ADDR_EDGE_SELECT    = 2'h2;

    // ****************************************************
    // Fields of key_status_control
    // ****************************************************
    localparam int KPI_BIT_MODE  = 0;
    localparam int KPI_BIT_IRQEN = 1;
    localparam int KPI_BIT_ACK   = 2;
    localparam int KPI_BIT_FLAG  = 3;

    localparam int         KPI_NPINS     = 8;
    localparam int         KPI_NIMPL     = 4;
    localparam logic [7:0] KPI_IMPL_MASK = 8'h0f;
    localparam logic [7:0] KPI_RST_BYTE  = 8'h00;
    localparam logic [7:0] KPI_ZERO_BYTE = 8'h00;

    // ****************************************************
    // Carrier types
    // ****************************************************
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } kpi_bus_s;

    typedef struct packed {
        logic [7:0] pin_en;
        logic [7:0] pol;
        logic       irq_en;
        logic       mode;
        logic       flag;
        logic       armed;
        logic [7:0] rdata;
        logic       irq;
    } kpi_state_s;

endpackage : kpi_pkg

// >>> kpi_sync.sv
/*
 * Two-flop synchroniser for the keypad pins.
 * Assumes inputs are asynchronous to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module kpi_sync
    import kpi_pkg::*;
#(
    parameter int W = 8
)
(
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         arst_n,
    // Data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // ****************************************************
    // Two stages, first read only by second
    // ****************************************************
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : kpi_sync
`default_nettype wire

// >>> kpi_top.sv
/*
 * Keypad pin interrupt controller: three 8-bit registers, edge or
 * edge-and-level detection for all pins, detect flag and CPU request.
 * Assumes a single sys_clk domain, an 8-bit register port with read
 * data one cycle after the read strobe, and pins from outside.
 */
// Design decisions made here: strobed register access and the register addresses.
// Summary of operation
// - Status register bits 7:4 always read zero.
// - Bit 3 is the read-only detect flag; writes leave it unchanged.
// - Bit 2 acknowledge clears the flag when written 1; reads zero.
// - Bit 1 gates the flag onto the CPU interrupt request.
// - Bit 0 selects edge-only or edge-and-level detection for all pins.
// - A pin whose enable bit is zero is ignored.
// - Polarity bit 0 means falling/low, 1 means rising/high.
// - Up to eight pins, each enabled by its own bit.
// - Falling edge: sampled one then zero on consecutive cycles.
// - Rising edge: sampled zero then one on consecutive cycles.
// - New edge needs all enabled inputs deasserted first, and after each.
// - Edge-only mode: valid edge sets flag; request if enabled.
// - Edge-and-level mode: edge or asserted level sets flag.
// - Level mode acknowledge clears only if all enabled inputs deasserted.
// - Polarity bit picks pull direction: zero pullup, one pulldown.
// - Only four pins exist; upper positions have nothing behind them.
// - Light stop: detection must still wake the processor; wake_req here follows the request, so only with bit 1 set.
// - Deep stop: unit is held in reset until wake.
`timescale 1ns/1ps
`default_nettype none
module kpi_top
    import kpi_pkg::*;
(
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    // Register port
    input  wire logic [1:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    // Pins
    input  wire logic [KPI_NIMPL-1:0] keypad_input_pin,
    // Pull control towards the pads
    input  wire logic [KPI_NIMPL-1:0] port_pull_enable,
    output logic      [KPI_NIMPL-1:0] pull_up_en,
    output logic      [KPI_NIMPL-1:0] pull_down_en,
    // Interrupt request and stop-mode wake
    output logic                      irq_req,
    output logic                      wake_req
);

    kpi_state_s       st_q;
    kpi_state_s       st_d;
    kpi_bus_s         bus;
    logic [7:0]       pin_s;
    logic [7:0]       pin_prev_q;
    logic [7:0]       pull_d;
    logic [7:0]       act_now;
    logic [7:0]       act_prev;
    logic             any_edge;
    logic             any_level;
    logic             set_flag;
    logic             ack;
    logic [KPI_NIMPL-1:0] raw_pins;
    logic [KPI_NIMPL-1:0] sync_pins;

    assign bus.addr  = reg_addr;
    assign bus.wdata = reg_wdata;
    assign bus.wr    = reg_wr;
    assign bus.rd    = reg_rd;
    assign raw_pins  = keypad_input_pin;

    // ****************************************************
    // Pin synchroniser
    // ****************************************************
    kpi_sync #(.W(KPI_NIMPL)) u_sync
    (
        .sys_clk  (sys_clk),
        .arst_n   (arst_n),
        .async_in (raw_pins),
        .sync_out (sync_pins)
    );

    assign pin_s = {{(KPI_NPINS-KPI_NIMPL){1'b0}}, sync_pins};

    // disabled pins masked out
    // Asserted when the pin equals its polarity bit; unbuilt positions masked
    assign act_now  = ~(pin_s ^ st_q.pol) & st_q.pin_en & KPI_IMPL_MASK;
    assign act_prev = ~(pin_prev_q ^ st_q.pol) & st_q.pin_en & KPI_IMPL_MASK;

    assign any_edge  = |(act_now & ~act_prev);
    assign any_level = |act_now;
    assign ack = bus.wr && bus.addr == KPI_ADDR_STATUS_CONTROL
                 && bus.wdata[KPI_BIT_ACK];

    assign set_flag = (any_edge && st_q.armed)
                      || (st_q.mode && any_level);

    // ****************************************************
    // Next-state logic
    // ****************************************************
    always_comb
    begin
        st_d = st_q;
        // rearm once all enabled inputs idle
        if (!any_level)
            st_d.armed = 1'b1;
        else if (set_flag)
            st_d.armed = 1'b0;
        if (bus.wr)
        begin
            case (bus.addr)
                KPI_ADDR_STATUS_CONTROL:
                begin
                    st_d.irq_en = bus.wdata[KPI_BIT_IRQEN];
                    st_d.mode   = bus.wdata[KPI_BIT_MODE];
                end
                KPI_ADDR_PIN_ENABLE:  st_d.pin_en = bus.wdata;
                KPI_ADDR_EDGE_SELECT: st_d.pol    = bus.wdata;
                default: ;
            endcase
        end
        // ack clears; level mode keeps flag while asserted
        if (ack && !(st_q.mode && any_level))
            st_d.flag = 1'b0;
        // Set wins over a same-cycle acknowledge
        if (set_flag)
            st_d.flag = 1'b1;
        st_d.rdata = KPI_ZERO_BYTE;
        if (bus.rd)
        begin
            case (bus.addr)
                // upper nibble and ack bit read zero
                KPI_ADDR_STATUS_CONTROL:
                begin
                    st_d.rdata[KPI_BIT_FLAG]  = st_q.flag;
                    st_d.rdata[KPI_BIT_IRQEN] = st_q.irq_en;
                    st_d.rdata[KPI_BIT_MODE]  = st_q.mode;
                end
                KPI_ADDR_PIN_ENABLE:  st_d.rdata = st_q.pin_en;
                KPI_ADDR_EDGE_SELECT: st_d.rdata = st_q.pol;
                default:              st_d.rdata = KPI_ZERO_BYTE;
            endcase
        end
        st_d.irq = st_d.flag && st_d.irq_en;
    end

    assign pull_d = {{(KPI_NPINS-KPI_NIMPL){1'b0}}, port_pull_enable}
                    & st_q.pin_en;

    // ****************************************************
    // State registers
    // ****************************************************
    // everything resets to zero; deep stop holds arst_n
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q       <= '0;
            pin_prev_q <= KPI_RST_BYTE;
            pull_up_en <= '0;
            pull_down_en <= '0;
            wake_req   <= 1'b0;
        end
        else
        begin
            st_q       <= st_d;
            pin_prev_q <= pin_s;
            pull_up_en   <= pull_d[KPI_NIMPL-1:0] & ~st_q.pol[KPI_NIMPL-1:0];
            pull_down_en <= pull_d[KPI_NIMPL-1:0] & st_q.pol[KPI_NIMPL-1:0];
            // wake whenever a request would be raised
            wake_req   <= st_d.irq;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign irq_req   = st_q.irq;

    // ****************************************************
    // Assertions
    // ****************************************************
    sequence s_ack_w;
        bus.wr && bus.addr == KPI_ADDR_STATUS_CONTROL && bus.wdata[KPI_BIT_ACK];
    endsequence

    property p_irq_gate;
        @(posedge sys_clk) disable iff (!arst_n)
        irq_req == (st_q.flag && st_q.irq_en);
    endproperty

    upper_zero_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $past(bus.rd) && $past(bus.addr) == KPI_ADDR_STATUS_CONTROL
        |-> reg_rdata[7:KPI_BIT_ACK] == {1'b0, 1'b0, 1'b0, 1'b0, st_q.flag, 1'b0}
        || $changed(st_q.flag)) else $error("status upper bits not zero");
    irq_gate_a: assert property (p_irq_gate) else $error("irq not gated");
    edge_set_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        any_edge && st_q.armed |=> st_q.flag) else $error("edge lost");
    level_set_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_q.mode && any_level |=> st_q.flag) else $error("level lost");
    level_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_ack_w ##0 (st_q.mode && any_level) |=> st_q.flag)
        else $error("flag cleared while asserted");
    ack_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_ack_w ##0 !any_level |=> !st_q.flag) else $error("ack failed");
    flag_stable_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !set_flag && !ack |=> $stable(st_q.flag)) else $error("flag moved");
    disabled_pin_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_q.pin_en == KPI_ZERO_BYTE |-> !set_flag) else $error("disabled pin");
    rearm_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !st_q.armed && any_level |=> !st_q.armed) else $error("early rearm");

endmodule : kpi_top
`default_nettype wire

// >>> tb.sv
/*
 * Self-checking bench for the keypad pin interrupt block.
 * Assumes kpi_pkg, kpi_top and the keypad model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, act) \
    begin comparisons++; if ((act) !== (exp)) begin failures++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, act); end end
module tb
    import kpi_pkg::*;
;
    // ****************************************************
    // Signals
    // ****************************************************
    logic       sys_clk, arst_n, reg_wr, reg_rd, irq_req, wake_req;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [3:0] keypad_input_pin, port_pull_enable, pull_up_en, pull_down_en;
    logic [3:0] key_press, key_level;
    int         failures, comparisons, cycles;

    kpi_top kpi_top_inst (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .keypad_input_pin(keypad_input_pin), .port_pull_enable(port_pull_enable),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .irq_req(irq_req),
        .wake_req(wake_req));
    kpi_keypad kpi_keypad_inst (.sys_clk(sys_clk), .key_press(key_press),
        .key_level(key_level), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
        .pin(keypad_input_pin));

    // ****************************************************
    // Tasks
    // ****************************************************
    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : idle

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        `CHK($sformatf("register %0d", a), e, reg_rdata)
    endtask : rd_chk

    task automatic press(input logic [3:0] p, input logic [3:0] l);
        @(posedge sys_clk);
        key_press <= p;
        key_level <= l;
        idle(6);
    endtask : press

    // ****************************************************
    // Clock and timeout
    // ****************************************************
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Ceiling well above the roughly 180 cycles the tests need
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            finish_test();
        end
    end

    // ****************************************************
    // Tests
    // ****************************************************
    initial
    begin
        {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {port_pull_enable, key_press, key_level} = {4'hf, 8'h00};
        {failures, comparisons, cycles} = '0;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (int a = 0; a < 4; a++) rd_chk(a[1:0], KPI_RST_BYTE);
        // Masked setup order avoids a false request
        wr(KPI_ADDR_STATUS_CONTROL, 8'h00);
        wr(KPI_ADDR_EDGE_SELECT, 8'h00);
        wr(KPI_ADDR_PIN_ENABLE, 8'h0f);
        // Let pulls settle and pass the synchroniser before acknowledging
        idle(4);
        wr(KPI_ADDR_STATUS_CONTROL, 8'h04);
        wr(KPI_ADDR_STATUS_CONTROL, 8'h02);
        idle(2);
        `CHK("pull up", 4'hf, pull_up_en)
        rd_chk(KPI_ADDR_STATUS_CONTROL, 8'h02);
        press(4'h1, 4'h0);
        rd_chk(KPI_ADDR_STATUS_CONTROL, 8'h0a);
        `CHK("irq", 1'b1, irq_req)
        `CHK("wake", 1'b1, wake_req)
        wr(KPI_ADDR_STATUS_CONTROL, 8'h0e);
        rd_chk(KPI_ADDR_STATUS_CONTROL, 8'h02);
        `CHK("irq", 1'b0, irq_req)
        press(4'h3, 4'h0);
        rd_chk(KPI_ADDR_STATUS_CONTROL, 8'h02);
        press(4'h0, 4'h0);
        press(4'h2, 4'h0);
        rd_chk(KPI_ADDR_STATUS_CONTROL, 8'h0a);
        wr(KPI_ADDR_STATUS_CONTROL, 8'h06);
        press(4'h0, 4'h0);
        wr(KPI_ADDR_PIN_ENABLE, 8'h0b);
        press(4'h4, 4'h0);
        rd_chk(KPI_ADDR_STATUS_CONTROL, 8'h02);
        wr(KPI_ADDR_STATUS_CONTROL, 8'h00);
        press(4'h1, 4'h0);
        rd_chk(KPI_ADDR_STATUS_CONTROL, 8'h08);
        `CHK("irq masked", 1'b0, irq_req)
        press(4'h0, 4'h0);
        wr(KPI_ADDR_STATUS_CONTROL, 8'h04);
        wr(KPI_ADDR_STATUS_CONTROL, 8'h03);
        press(4'h1, 4'h0);
        rd_chk(KPI_ADDR_STATUS_CONTROL, 8'h0b);
        wr(KPI_ADDR_STATUS_CONTROL, 8'h07);
        rd_chk(KPI_ADDR_STATUS_CONTROL, 8'h0b);
        press(4'h0, 4'h0);
        wr(KPI_ADDR_STATUS_CONTROL, 8'h07);
        rd_chk(KPI_ADDR_STATUS_CONTROL, 8'h03);
        wr(KPI_ADDR_STATUS_CONTROL, 8'h00);
        wr(KPI_ADDR_EDGE_SELECT, 8'h0f);
        idle(4);
        `CHK("pull down", 4'hb, pull_down_en)
        wr(KPI_ADDR_STATUS_CONTROL, 8'h04);
        wr(KPI_ADDR_STATUS_CONTROL, 8'h02);
        press(4'h2, 4'h2);
        rd_chk(KPI_ADDR_STATUS_CONTROL, 8'h0a);
        wr(KPI_ADDR_EDGE_SELECT, 8'hff);
        rd_chk(KPI_ADDR_EDGE_SELECT, 8'hff);
        wr(KPI_ADDR_STATUS_CONTROL, 8'hf4);
        rd_chk(KPI_ADDR_STATUS_CONTROL, 8'h00);
        wr(2'h3, 8'hff);
        rd_chk(2'h3, KPI_ZERO_BYTE);
        rd_chk(KPI_ADDR_PIN_ENABLE, 8'h0b);
        finish_test();
    end
endmodule : tb
`default_nettype wire
